// [logic/tbg_pkg.sv]
package tbg_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int          ADDR_W    = 16;
  localparam int          IDX_W     = 14;
  localparam int          DATA_W    = 32;
  localparam int          PORT_W    = 8;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [13:0] IDX_A_LATCH  = 14'h0007;
  localparam logic [13:0] IDX_A_DIR    = 14'h1f8d;
  localparam logic [13:0] IDX_B_LATCH  = 14'h0008;
  localparam logic [13:0] IDX_C_LATCH  = 14'h0009;
  localparam logic [13:0] IDX_B_DIR    = 14'h1f8e;
  localparam logic [13:0] IDX_C_DIR    = 14'h1f8f;
  localparam logic [13:0] IDX_B_ODE    = 14'h1f86;
  localparam logic [13:0] IDX_C_ODE    = 14'h1f87;
  localparam logic [13:0] IDX_CONV_CTL = 14'h0020;

  // ==========================================================================
  // Converter control field positions
  localparam int          CONV_AIND_BIT = 0;
  localparam int          CONV_DBG_BIT  = 1;
  localparam int          CONV_BUSY_BIT = 2;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [7:0]  DIR_RST    = 8'h00;
  localparam logic [7:0]  ODE_RST    = 8'h00;
  localparam logic        AIND_RST   = 1'b1;
  localparam logic        DBG_RST    = 1'b0;

  // ==========================================================================
  // Bus slave states
  typedef enum logic [2:0] {
    TBG_IDLE   = 3'b001,
    TBG_ACCESS = 3'b010,
    TBG_DONE   = 3'b100
  } tbg_bus_state_t;

endpackage : tbg_pkg

// [logic/tbg_pin_cell.sv]
`timescale 1ns/1ns
module tbg_pin_cell #(
  parameter bit SHARED = 1'b0
) (
  // Configuration
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] lat_i,
  input  wire logic [7:0] ode_i,
  input  wire logic       aind_i,
  input  wire logic       rmw_i,
  // Pins
  input  wire logic [7:0] pin_i,
  // Results
  output logic      [7:0] out_o,
  output logic      [7:0] oe_o,
  output logic      [7:0] rd_o,
  output logic      [7:0] ana_o
);

  // ==========================================================================
  // Per-pin drive and read path
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      if (SHARED) begin : g_shared
        assign out_o[gi] = lat_i[gi];
        assign oe_o[gi]  = dir_i[gi];
        // Input with latch zero masks the pin: analog or fixed-low input reads zero
        assign rd_o[gi]  = dir_i[gi] | lat_i[gi] ? pin_i[gi] : 1'b0;
        assign ana_o[gi] = ~dir_i[gi] & ~lat_i[gi] & ~aind_i;
      end else begin : g_plain
        assign out_o[gi] = ode_i[gi] ? 1'b0 : lat_i[gi];
        // Open-drain releases the pin for a one
        assign oe_o[gi]  = dir_i[gi] & (~ode_i[gi] | ~lat_i[gi]);
        assign rd_o[gi]  = (rmw_i & ode_i[gi]) ? lat_i[gi] : pin_i[gi];
        assign ana_o[gi] = 1'b0;
      end
    end
  endgenerate

endmodule : tbg_pin_cell

// [logic/tbg_top.sv]
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module tbg_top (
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [15:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  input  wire logic        READ_MODIFY_WRITE_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Analog-shared port
  input  wire logic [7:0]  PA_PIN_I,
  output logic      [7:0]  PA_PIN_O,
  output logic      [7:0]  PA_PIN_OE_O,
  output logic      [7:0]  PA_ANALOG_O,
  // Second port
  input  wire logic [7:0]  PB_PIN_I,
  output logic      [7:0]  PB_PIN_O,
  output logic      [7:0]  PB_PIN_OE_O,
  // Third port
  input  wire logic [7:0]  PC_PIN_I,
  output logic      [7:0]  PC_PIN_O,
  output logic      [7:0]  PC_PIN_OE_O,
  // Converter and debug
  input  wire logic        CONV_BUSY_I,
  input  wire logic        DEBUG_OUTPUT_TWO_I,
  output logic             CONV_START_O
);

  // ==========================================================================
  // State
  typedef struct packed {
    tbg_pkg::tbg_bus_state_t bus;
    logic [7:0]              a_lat;
    logic [7:0]              a_dir;
    logic [7:0]              b_lat;
    logic [7:0]              b_dir;
    logic [7:0]              b_ode;
    logic [7:0]              c_lat;
    logic [7:0]              c_dir;
    logic [7:0]              c_ode;
    logic                    aind;
    logic                    dbg_en;
    logic                    conv_start;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic [7:0]              a_out;
    logic [7:0]              a_oe;
    logic [7:0]              a_ana;
    logic [7:0]              b_out;
    logic [7:0]              b_oe;
    logic [7:0]              c_out;
    logic [7:0]              c_oe;
  } tbg_state_t;

  tbg_state_t  state_reg;
  tbg_state_t  state_next;

  logic [7:0]  a_out_w;
  logic [7:0]  a_oe_w;
  logic [7:0]  a_rd_w;
  logic [7:0]  a_ana_w;
  logic [7:0]  b_out_w;
  logic [7:0]  b_oe_w;
  logic [7:0]  b_rd_w;
  logic [7:0]  c_out_w;
  logic [7:0]  c_oe_w;
  logic [7:0]  c_rd_w;
  logic [13:0] idx;
  logic        hit;
  logic [31:0] rd_word;
  logic        wr_fire;

  // ==========================================================================
  // Pin cells
  tbg_pin_cell #(.SHARED(1'b1)) u_port_a (
    .dir_i  (state_reg.a_dir),
    .lat_i  (state_reg.a_lat),
    .ode_i  (tbg_pkg::ODE_RST),
    .aind_i (state_reg.aind),
    .rmw_i  (READ_MODIFY_WRITE_I),
    .pin_i  (PA_PIN_I),
    .out_o  (a_out_w),
    .oe_o   (a_oe_w),
    .rd_o   (a_rd_w),
    .ana_o  (a_ana_w)
  );

  tbg_pin_cell #(.SHARED(1'b0)) u_port_b (
    .dir_i  (state_reg.b_dir),
    .lat_i  (state_reg.b_lat),
    .ode_i  (state_reg.b_ode),
    .aind_i (1'b1),
    .rmw_i  (READ_MODIFY_WRITE_I),
    .pin_i  (PB_PIN_I),
    .out_o  (b_out_w),
    .oe_o   (b_oe_w),
    .rd_o   (b_rd_w),
    .ana_o  ()
  );

  tbg_pin_cell #(.SHARED(1'b0)) u_port_c (
    .dir_i  (state_reg.c_dir),
    .lat_i  (state_reg.c_lat),
    .ode_i  (state_reg.c_ode),
    .aind_i (1'b1),
    .rmw_i  (READ_MODIFY_WRITE_I),
    .pin_i  (PC_PIN_I),
    .out_o  (c_out_w),
    .oe_o   (c_oe_w),
    .rd_o   (c_rd_w),
    .ana_o  ()
  );

  // ==========================================================================
  // Address decode and read mux
  assign idx = PADDR_I[15:2];

  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (idx)
      tbg_pkg::IDX_A_LATCH:  rd_word[7:0] = a_rd_w;
      tbg_pkg::IDX_A_DIR:    rd_word[7:0] = state_reg.a_dir;
      tbg_pkg::IDX_B_LATCH:  rd_word[7:0] = b_rd_w;
      tbg_pkg::IDX_C_LATCH:  rd_word[7:0] = c_rd_w;
      tbg_pkg::IDX_B_DIR:    rd_word[7:0] = state_reg.b_dir;
      tbg_pkg::IDX_C_DIR:    rd_word[7:0] = state_reg.c_dir;
      tbg_pkg::IDX_B_ODE:    rd_word[7:0] = state_reg.b_ode;
      tbg_pkg::IDX_C_ODE:    rd_word[7:0] = state_reg.c_ode;
      tbg_pkg::IDX_CONV_CTL: begin
        rd_word[tbg_pkg::CONV_AIND_BIT] = state_reg.aind;
        rd_word[tbg_pkg::CONV_DBG_BIT]  = state_reg.dbg_en;
        rd_word[tbg_pkg::CONV_BUSY_BIT] = CONV_BUSY_I;
      end
      default:               hit = 1'b0;
    endcase
  end

  // Only byte lane zero carries register data
  assign wr_fire = (state_reg.bus == tbg_pkg::TBG_ACCESS) & PSEL_I & PENABLE_I
                   & PWRITE_I & PSTRB_I[0] & hit;

  // ==========================================================================
  // Next state
  always_comb begin
    state_next            = state_reg;
    state_next.conv_start = 1'b0;
    state_next.pready     = 1'b0;
    state_next.pslverr    = 1'b0;
    case (state_reg.bus)
      tbg_pkg::TBG_IDLE: begin
        // Setup cycle: read sampled here so the answer leaves a flop
        if (PSEL_I & ~PENABLE_I) begin
          state_next.bus     = tbg_pkg::TBG_ACCESS;
          state_next.pready  = 1'b1;
          state_next.pslverr = ~hit;
          state_next.prdata  = PWRITE_I ? 32'h0000_0000 : rd_word;
        end
      end
      tbg_pkg::TBG_ACCESS: begin
        state_next.bus    = tbg_pkg::TBG_IDLE;
        state_next.prdata = 32'h0000_0000;
        if (wr_fire) begin
          case (idx)
            tbg_pkg::IDX_A_LATCH: state_next.a_lat = PWDATA_I[7:0];
            // Analog pins kept out of output mode is up to software
            tbg_pkg::IDX_A_DIR:   state_next.a_dir = PWDATA_I[7:0];
            tbg_pkg::IDX_B_LATCH: state_next.b_lat = PWDATA_I[7:0];
            tbg_pkg::IDX_C_LATCH: state_next.c_lat = PWDATA_I[7:0];
            tbg_pkg::IDX_B_DIR:   state_next.b_dir = PWDATA_I[7:0];
            tbg_pkg::IDX_C_DIR:   state_next.c_dir = PWDATA_I[7:0];
            tbg_pkg::IDX_B_ODE:   state_next.b_ode = PWDATA_I[7:0];
            tbg_pkg::IDX_C_ODE:   state_next.c_ode = PWDATA_I[7:0];
            tbg_pkg::IDX_CONV_CTL: begin
              state_next.aind       = PWDATA_I[tbg_pkg::CONV_AIND_BIT];
              state_next.dbg_en     = PWDATA_I[tbg_pkg::CONV_DBG_BIT];
              state_next.conv_start = ~PWDATA_I[tbg_pkg::CONV_AIND_BIT];
            end
            default: ;
          endcase
        end
      end
      default: begin
        state_next.bus = tbg_pkg::TBG_IDLE;
      end
    endcase
    // Pin drive registered; one cycle behind the latches
    state_next.a_out = a_out_w;
    // Debug output gated by latch seven, so a clear latch keeps pin low
    if (state_reg.dbg_en) begin
      state_next.a_out[7] = DEBUG_OUTPUT_TWO_I & state_reg.a_lat[7];
    end
    state_next.a_oe  = a_oe_w;
    state_next.a_ana = a_ana_w;
    state_next.b_out = b_out_w;
    state_next.b_oe  = b_oe_w;
    state_next.c_out = c_out_w;
    state_next.c_oe  = c_oe_w;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_reg        <= '0;
      state_reg.bus    <= tbg_pkg::TBG_IDLE;
      state_reg.a_lat  <= tbg_pkg::LATCH_RST;
      state_reg.a_dir  <= tbg_pkg::DIR_RST;
      state_reg.aind   <= tbg_pkg::AIND_RST;
      state_reg.dbg_en <= tbg_pkg::DBG_RST;
      state_reg.b_lat  <= tbg_pkg::LATCH_RST;
      state_reg.b_dir  <= tbg_pkg::DIR_RST;
      state_reg.b_ode  <= tbg_pkg::ODE_RST;
      state_reg.c_lat  <= tbg_pkg::LATCH_RST;
      state_reg.c_dir  <= tbg_pkg::DIR_RST;
      state_reg.c_ode  <= tbg_pkg::ODE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign PRDATA_O     = state_reg.prdata;
  assign PREADY_O     = state_reg.pready;
  assign PSLVERR_O    = state_reg.pslverr;
  assign PA_PIN_O     = state_reg.a_out;
  assign PA_PIN_OE_O  = state_reg.a_oe;
  assign PA_ANALOG_O  = state_reg.a_ana;
  assign PB_PIN_O     = state_reg.b_out;
  assign PB_PIN_OE_O  = state_reg.b_oe;
  assign PC_PIN_O     = state_reg.c_out;
  assign PC_PIN_OE_O  = state_reg.c_oe;
  assign CONV_START_O = state_reg.conv_start;

endmodule : tbg_top

// [tb/tbg_props.sv]
`timescale 1ns/1ns
// ==========================================================================
// Port checker
module tbg_props (
  // Watched ports
  input wire logic        CLOCK_I,
  input wire logic        SYS_RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [7:0]  PA_PIN_OE_O,
  input wire logic [7:0]  PA_ANALOG_O,
  input wire logic [7:0]  PB_PIN_OE_O,
  input wire logic [7:0]  PC_PIN_OE_O,
  input wire logic        CONV_START_O
);
  logic [13:0] idx;
  logic        wr_edge;
  logic        conv0;
  logic        mapped;
  assign idx     = PADDR_I[15:2];
  assign wr_edge = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  assign conv0   = wr_edge & PSTRB_I[0] & ~PWDATA_I[0] & (idx == tbg_pkg::IDX_CONV_CTL);
  assign mapped  = idx inside {tbg_pkg::IDX_A_LATCH, tbg_pkg::IDX_A_DIR, tbg_pkg::IDX_B_LATCH,
    tbg_pkg::IDX_C_LATCH, tbg_pkg::IDX_B_DIR, tbg_pkg::IDX_C_DIR, tbg_pkg::IDX_B_ODE,
    tbg_pkg::IDX_C_ODE, tbg_pkg::IDX_CONV_CTL};
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  a_unmapped_error: assert property (PREADY_O |-> PSLVERR_O == !mapped)
    else $error("error flag wrong for address");
  a_error_data_zero: assert property (PREADY_O && PSLVERR_O |-> PRDATA_O == 32'h00000000)
    else $error("data on error response");
  a_upper_bits_zero: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_conv_start: assert property (conv0 |=> CONV_START_O)
    else $error("no conversion start");
  a_start_cause: assert property (CONV_START_O |-> $past(conv0))
    else $error("spurious conversion start");
  a_analog_read_zero: assert property (PREADY_O && !PWRITE_I
    && idx == tbg_pkg::IDX_A_LATCH |-> (PRDATA_O[7:0] & PA_ANALOG_O) == 8'h00)
    else $error("analog bit read nonzero");
  a_reset_state: assert property ($fell(SYS_RST_I)
    |-> (PA_PIN_OE_O | PB_PIN_OE_O | PC_PIN_OE_O | PA_ANALOG_O) == 8'h00)
    else $error("pins active after reset");
  // Enables leave a flop one edge after the register, so the write lies two edges back
  a_enable_after_write: assert property (!$past(wr_edge, 2)
    |-> $stable(PA_PIN_OE_O) && $stable(PB_PIN_OE_O) && $stable(PC_PIN_OE_O))
    else $error("drive enable moved without write");
  c_conv_start: cover property (conv0);
  c_error: cover property (PREADY_O && PSLVERR_O);
  c_analog: cover property (PA_ANALOG_O != 8'h00);
endmodule : tbg_props

// [tb/tbg_board.sv]
`timescale 1ns/1ns
// ==========================================================================
// Board levels and converter busy model
module tbg_board (
  // Clock
  input  wire logic       clk_i,
  // Device drive
  input  wire logic [7:0] a_o_i,
  input  wire logic [7:0] a_oe_i,
  input  wire logic [7:0] b_o_i,
  input  wire logic [7:0] b_oe_i,
  input  wire logic [7:0] c_o_i,
  input  wire logic [7:0] c_oe_i,
  input  wire logic       start_i,
  // Board sources
  input  wire logic [7:0] a_ext_i,
  input  wire logic [7:0] b_ext_i,
  input  wire logic [7:0] c_ext_i,
  // Wire levels
  output logic      [7:0] a_pin_o,
  output logic      [7:0] b_pin_o,
  output logic      [7:0] c_pin_o,
  output logic            busy_o
);
  logic [4:0] busy_reg = 5'h00;
  // Released bits show the board source, never the last drive
  assign a_pin_o = (a_oe_i & a_o_i) | (~a_oe_i & a_ext_i);
  assign b_pin_o = (b_oe_i & b_o_i) | (~b_oe_i & b_ext_i);
  assign c_pin_o = (c_oe_i & c_o_i) | (~c_oe_i & c_ext_i);
  assign busy_o  = busy_reg != 5'h00;
  always_ff @(posedge clk_i) begin
    if (start_i) busy_reg <= 5'h10;
    else if (busy_o) busy_reg <= busy_reg - 5'h01;
  end
endmodule : tbg_board

// [tb/three_byte_gpio_ports_test.sv]
`timescale 1ns/1ns
module three_byte_gpio_ports_test;
  typedef struct packed {
    logic [1:0] p;
    logic [7:0] dir, lat, ode, ext;
    logic       read_modify_write, aind;
    logic [7:0] rd, oe, drv;
  } tbg_row_t;
  // ==========================================================================
  // Signals
  logic        CLOCK_I = 1'b0, SYS_RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0;
  logic        PWRITE_I = 1'b0, READ_MODIFY_WRITE_I = 1'b0, PREADY_O, PSLVERR_O;
  logic        DEBUG_OUTPUT_TWO_I = 1'b0, CONV_START_O, CONV_BUSY_I;
  logic [15:0] PADDR_I = 16'h0000;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, d;
  logic [3:0]  PSTRB_I = 4'hf;
  logic [7:0]  PA_PIN_I, PA_PIN_O, PA_PIN_OE_O, PA_ANALOG_O, PB_PIN_I, PB_PIN_O, PB_PIN_OE_O;
  logic [7:0]  PC_PIN_I, PC_PIN_O, PC_PIN_OE_O, ext = 8'h00;
  logic [15:0] g;
  logic        er;
  tbg_row_t    r;
  int          fail_count = 0, checks = 0, cyc = 0, starts = 0, n;
  logic [13:0] lat_idx [3] = '{tbg_pkg::IDX_A_LATCH, tbg_pkg::IDX_B_LATCH, tbg_pkg::IDX_C_LATCH};
  logic [13:0] dir_idx [3] = '{tbg_pkg::IDX_A_DIR, tbg_pkg::IDX_B_DIR, tbg_pkg::IDX_C_DIR};
  logic [13:0] ode_idx [3] = '{tbg_pkg::IDX_B_ODE, tbg_pkg::IDX_B_ODE, tbg_pkg::IDX_C_ODE};
  tbg_row_t rows [8] = '{
    '{2'd0, 8'h0f, 8'h3c, 8'h00, 8'ha5, 1'b0, 1'b1, 8'h2c, 8'h0f, 8'h0c},
    '{2'd0, 8'h00, 8'hf0, 8'h00, 8'h5a, 1'b0, 1'b0, 8'h50, 8'h00, 8'h00},
    '{2'd0, 8'h00, 8'h00, 8'h00, 8'hff, 1'b0, 1'b1, 8'h00, 8'h00, 8'h00},
    '{2'd1, 8'hff, 8'h0f, 8'h00, 8'h00, 1'b0, 1'b1, 8'h0f, 8'hff, 8'h0f},
    '{2'd1, 8'hff, 8'h0f, 8'hff, 8'h33, 1'b0, 1'b1, 8'h03, 8'hf0, 8'h00},
    '{2'd1, 8'hff, 8'h0f, 8'hff, 8'h33, 1'b1, 1'b1, 8'h0f, 8'hf0, 8'h00},
    '{2'd2, 8'h0f, 8'h55, 8'h0f, 8'hc3, 1'b1, 1'b1, 8'hc5, 8'h0a, 8'h00},
    '{2'd2, 8'h00, 8'h00, 8'h00, 8'h96, 1'b0, 1'b1, 8'h96, 8'h00, 8'h00}};
  // ==========================================================================
  // Design and board
  tbg_top u_dut (.CLOCK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PSTRB_I, .READ_MODIFY_WRITE_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .PA_PIN_I, .PA_PIN_O,
    .PA_PIN_OE_O, .PA_ANALOG_O, .PB_PIN_I, .PB_PIN_O, .PB_PIN_OE_O, .PC_PIN_I, .PC_PIN_O,
    .PC_PIN_OE_O, .CONV_BUSY_I, .DEBUG_OUTPUT_TWO_I, .CONV_START_O);
  tbg_board u_board (.clk_i(CLOCK_I), .a_o_i(PA_PIN_O), .a_oe_i(PA_PIN_OE_O), .b_o_i(PB_PIN_O),
    .b_oe_i(PB_PIN_OE_O), .c_o_i(PC_PIN_O), .c_oe_i(PC_PIN_OE_O), .start_i(CONV_START_O),
    .a_ext_i(ext), .b_ext_i(ext), .c_ext_i(ext), .a_pin_o(PA_PIN_I), .b_pin_o(PB_PIN_I),
    .c_pin_o(PC_PIN_I), .busy_o(CONV_BUSY_I));
  always #20 CLOCK_I = ~CLOCK_I;
  // Sampling on the falling edge keeps clear of register updates
  always @(negedge CLOCK_I) begin
    cyc++;
    if (CONV_START_O === 1'b1) starts++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end
  // ==========================================================================
  // Tasks
  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic [13:0] idx, input logic wr, input logic [31:0] wd,
                     input logic read_modify_write, output logic [31:0] rd, output logic err);
    @(posedge CLOCK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= wr;
    PADDR_I <= {idx, 2'b00};
    PWDATA_I <= wd;
    READ_MODIFY_WRITE_I <= read_modify_write;
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    @(posedge CLOCK_I);
    while (PREADY_O !== 1'b1) @(posedge CLOCK_I);
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask : apb
  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    apb(idx, 1'b1, {24'h0, v}, 1'b0, d, er);
  endtask : wr
  task automatic rdc(input logic [13:0] idx, input logic read_modify_write, input logic [7:0] v);
    apb(idx, 1'b0, 32'h0, read_modify_write, d, er);
    cmp(d, {24'h0, v});
  endtask : rdc
  task automatic do_reset();
    SYS_RST_I <= 1'b1;
    repeat (4) @(posedge CLOCK_I);
    SYS_RST_I <= 1'b0;
  endtask : do_reset
  // ==========================================================================
  // Sequence
  initial begin
    do_reset();
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge CLOCK_I);
      ext <= r.ext;
      wr(dir_idx[r.p], r.dir);
      wr(lat_idx[r.p], r.lat);
      if (r.p != 2'd0) wr(ode_idx[r.p], r.ode);
      wr(tbg_pkg::IDX_CONV_CTL, {7'h0, r.aind});
      rdc(lat_idx[r.p], r.read_modify_write, r.rd);
      rdc(dir_idx[r.p], 1'b0, r.dir);
      @(negedge CLOCK_I);
      g = r.p == 2'd0 ? {PA_PIN_OE_O, PA_PIN_O} : r.p == 2'd1 ? {PB_PIN_OE_O, PB_PIN_O}
        : {PC_PIN_OE_O, PC_PIN_O};
      cmp({16'h0, g[15:8], g[7:0] & g[15:8]}, {16'h0, r.oe, r.drv});
      if (r.p == 2'd0) cmp({24'h0, PA_ANALOG_O}, {24'h0, ~r.dir & ~r.lat & {8{~r.aind}}});
    end
    // Debug output on shared pin seven, latch seven set first
    wr(tbg_pkg::IDX_A_LATCH, 8'h80);
    wr(tbg_pkg::IDX_A_DIR, 8'h80);
    wr(tbg_pkg::IDX_CONV_CTL, 8'h03);
    DEBUG_OUTPUT_TWO_I <= 1'b1;
    repeat (2) @(negedge CLOCK_I);
    cmp({24'h0, PA_PIN_O}, 32'h80);
    @(posedge CLOCK_I);
    DEBUG_OUTPUT_TWO_I <= 1'b0;
    repeat (2) @(negedge CLOCK_I);
    cmp({24'h0, PA_PIN_O}, 32'h0);
    n = starts;
    wr(tbg_pkg::IDX_CONV_CTL, 8'h00);
    repeat (2) @(negedge CLOCK_I);
    cmp(starts - n, 32'h1);
    rdc(tbg_pkg::IDX_CONV_CTL, 1'b0, 8'h04);
    repeat (20) @(posedge CLOCK_I);
    rdc(tbg_pkg::IDX_CONV_CTL, 1'b0, 8'h00);
    apb(14'h0100, 1'b0, 32'h0, 1'b0, d, er);
    cmp(d, 32'h0);
    cmp({31'h0, er}, 32'h1);
    // Mid-run reset over a dirty configuration
    ext <= 8'h00;
    do_reset();
    foreach (lat_idx[k]) begin
      rdc(lat_idx[k], 1'b0, 8'h00);
      rdc(dir_idx[k], 1'b0, 8'h00);
    end
    rdc(tbg_pkg::IDX_B_ODE, 1'b0, 8'h00);
    rdc(tbg_pkg::IDX_C_ODE, 1'b0, 8'h00);
    rdc(tbg_pkg::IDX_CONV_CTL, 1'b0, 8'h01);
    // Strobe lane zero low: write dropped
    PSTRB_I <= 4'he;
    wr(tbg_pkg::IDX_B_DIR, 8'hff);
    PSTRB_I <= 4'hf;
    rdc(tbg_pkg::IDX_B_DIR, 1'b0, 8'h00);
    @(negedge CLOCK_I);
    cmp({8'h0, PA_PIN_OE_O, PB_PIN_OE_O, PC_PIN_OE_O}, 32'h0);
    test_done();
  end
endmodule : three_byte_gpio_ports_test
bind tbg_top tbg_props u_props (.CLOCK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PWDATA_I, .PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .PA_PIN_OE_O, .PA_ANALOG_O,
  .PB_PIN_OE_O, .PC_PIN_OE_O, .CONV_START_O);
